// File: hw/persist_timer.v
// Fires once when a condition has held for a set number of cycles
`timescale 1ns/1ps
module persist_timer #(
  parameter CYCLES = 16
) (
  input wire sys_clk,
  input wire rst_b,
  input wire clk_en,
  input wire active,
  output reg fire
);
  // Cycles the condition has held so far
  reg [12:0] held;

  // Any gap restarts the count, so glitches never fire
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      held <= 13'h0000;
      fire <= 1'b0;
    end else if (clk_en) begin
      fire <= 1'b0;
      if (!active) begin
        held <= 13'h0000;
      end else if (held < CYCLES[12:0]) begin
        held <= held + 13'h0001;
        // One pulse at the end of the wait
        if (held == CYCLES[12:0] - 13'h0001) begin
          fire <= 1'b1;
        end
      end
    end
  end
endmodule // persist_timer

// File: hw/reset_cause_and_brownout_control.v
// Reset cause flags, brown-out and threshold-code reset control
//
// Operation
// - Persistent brown-out resets; threshold register kept
// - Undefined code resets after delay, register restored
// - Brown-out flag bit 2, cleared by zero write
// - Bad-code flag bit 1, cleared by zero write
// - Running watchdog time-out: reset, timeout flag set
// - Idle/sleep time-out: PC/SP only, both flags
// - Power-on clears flags; pin/brown-out keep them
// - Power-on gives full core reset sequence
// - Threshold powers up 0x66, fixed low level
// - No brown-out detection in idle or sleep
`timescale 1ns/1ps
`include "rst_ctl_defines.vh"
module reset_cause_and_brownout_control (
  input wire sys_clk,
  input wire rst_b,
  input wire clk_en,
  // Avalon-MM slave, byte address
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // Supply comparator: high while supply is below threshold
  input wire supply_low,
  // External reset pin, active low
  input wire external_reset_pin_b,
  // One-cycle watchdog overflow
  input wire wdt_timeout,
  // Core operating mode
  input wire [1:0] cpu_mode,
  // Core enters halt / clears the watchdog
  input wire halt_cmd,
  input wire clr_wdt_cmd,
  // Full reset to core: PC, interrupts, WDT, ports, SP
  output wire sys_reset,
  // Reduced reset: program counter and stack pointer only
  output wire pc_sp_reset,
  // Comparator enable and selected code
  output reg brownout_detect_en,
  output reg [7:0] threshold_select_code,
  // Core status flags
  output reg watchdog_timeout_flag,
  output reg powerdown_flag,
  // Level interrupt
  output reg irq
);

  // True for the five defined threshold codes
  function code_ok;
    input [7:0] c;
    begin
      code_ok = (c == `THRESH_POR) || (c == `THRESH_CODE_A) ||
        (c == `THRESH_CODE_B) || (c == `THRESH_CODE_C) ||
        (c == `THRESH_CODE_D);
    end
  endfunction

  // Byte lane 0 of a 32-bit write
  function [7:0] lane0;
    input [31:0] d;
    input [3:0] be;
    input [7:0] old;
    begin
      lane0 = be[0] ? d[7:0] : old;
    end
  endfunction

  // Accepted write to the register at one offset
  function wr_hit;
    input go;
    input [4:0] a;
    input be0;
    input [4:0] ofs;
    begin
      wr_hit = go && be0 && (a == ofs);
    end
  endfunction

  // Threshold select register
  reg [7:0] brownout_threshold_select;
  // Reset cause flags, bits 2 and 1 used
  reg brownout_event_flag;
  reg bad_threshold_code_flag;
  // Interrupt status and mask
  reg [3:0] irq_status;
  reg [3:0] irq_mask;
  // Previous pin level for edge detection
  reg ext_pin_q;
  // Read data staged for the answer cycle
  reg [31:0] rd_mux;

  // Timer outputs
  wire bo_fire;
  wire bad_fire;
  // Decoded bus write, taken at the answer edge, and internal conditions
  wire wr_go;
  wire low_power;
  wire code_valid;
  wire wdt_full;
  wire wdt_light;
  wire ext_event;
  wire full_req;
  wire [3:0] irq_events;
  wire [7:0] wbyte;
  // Write strobes, one per writable register
  wire wr_thresh;
  wire wr_cause;
  wire wr_irq_st;
  wire wr_irq_mask;

  assign wr_go = avs_write && !avs_waitrequest;
  assign wbyte = lane0(avs_writedata, avs_byteenable, 8'h00);
  // Lane 0 must be enabled, or the write is dropped
  assign wr_thresh = wr_hit(wr_go, avs_address, avs_byteenable[0],
    `OFS_THRESH);
  assign wr_cause = wr_hit(wr_go, avs_address, avs_byteenable[0],
    `OFS_CAUSE);
  assign wr_irq_st = wr_hit(wr_go, avs_address, avs_byteenable[0],
    `OFS_IRQ_ST);
  assign wr_irq_mask = wr_hit(wr_go, avs_address, avs_byteenable[0],
    `OFS_IRQ_MASK);
  assign low_power = cpu_mode[1];
  assign code_valid = code_ok(brownout_threshold_select);
  // Time-out splits by mode
  assign wdt_full = wdt_timeout && !low_power;
  assign wdt_light = wdt_timeout && low_power;
  assign ext_event = ext_pin_q && !external_reset_pin_b;

  // Every source of a full reset; pin is a held level
  assign full_req = bo_fire || bad_fire || wdt_full ||
    !external_reset_pin_b;

  // Event bits for the interrupt status
  assign irq_events = {ext_event, wdt_timeout, bad_fire, bo_fire};

  // Brown-out must persist; comparator gated off in low power
  persist_timer #(
    .CYCLES(`BO_FILTER_CYC)
  ) u_bo_filter (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .active(supply_low && brownout_detect_en),
    .fire(bo_fire)
  );

  // Undefined code waits out its delay before reset
  persist_timer #(
    .CYCLES(`BAD_CODE_CYC)
  ) u_bad_code (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .active(!code_valid),
    .fire(bad_fire)
  );

  // Full reset, high from power-on until the hold count runs out
  reset_stretch #(
    .HOLD(`RST_HOLD_CYC),
    .POR_ON(1)
  ) u_full_rst (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .req(full_req),
    .rst_out(sys_reset)
  );

  // Reduced reset for time-out in idle or sleep
  reset_stretch #(
    .HOLD(`RST_HOLD_CYC),
    .POR_ON(0)
  ) u_light_rst (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .req(wdt_light),
    .rst_out(pc_sp_reset)
  );

  // Threshold register; the bad-code restore beats a write
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      brownout_threshold_select <= `THRESH_POR;
    end else if (clk_en) begin
      if (bad_fire) begin
        brownout_threshold_select <= `THRESH_POR;
      end else if (wr_thresh) begin
        brownout_threshold_select <= wbyte;
      end
      // A brown-out reset leaves the code alone
    end
  end

  // Comparator controls, registered towards the analog side
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      brownout_detect_en <= 1'b0;
      threshold_select_code <= `THRESH_POR;
    end else if (clk_en) begin
      // Off in idle and sleep, and for an undefined code
      brownout_detect_en <= code_valid && !low_power;
      threshold_select_code <= brownout_threshold_select;
    end
  end

  // Cause flags: hardware set wins over a software clear
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      brownout_event_flag <= 1'b0;
      bad_threshold_code_flag <= 1'b0;
    end else if (clk_en) begin
      if (bo_fire) begin
        brownout_event_flag <= 1'b1;
      end else if (wr_cause && !wbyte[`CAUSE_BO_BIT]) begin
        // Only a zero clears; a one is ignored
        brownout_event_flag <= 1'b0;
      end
      if (bad_fire) begin
        bad_threshold_code_flag <= 1'b1;
      end else if (wr_cause && !wbyte[`CAUSE_BAD_BIT]) begin
        bad_threshold_code_flag <= 1'b0;
      end
    end
  end

  // Core status flags; reset events beat core commands
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      // Power-on clears both
      watchdog_timeout_flag <= 1'b0;
      powerdown_flag <= 1'b0;
    end else if (clk_en) begin
      if (wdt_light) begin
        watchdog_timeout_flag <= 1'b1;
        powerdown_flag <= 1'b1;
      end else if (wdt_full) begin
        // Powerdown flag left as it was
        watchdog_timeout_flag <= 1'b1;
      end else if (clr_wdt_cmd) begin
        watchdog_timeout_flag <= 1'b0;
        powerdown_flag <= 1'b0;
      end else if (halt_cmd) begin
        watchdog_timeout_flag <= 1'b0;
        powerdown_flag <= 1'b1;
      end
      // Pin and brown-out resets touch neither flag
    end
  end

  // Pin level history for the interrupt edge
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      ext_pin_q <= 1'b1;
    end else if (clk_en) begin
      ext_pin_q <= external_reset_pin_b;
    end
  end

  // Sticky interrupt status, write one to clear, set wins
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      irq_status <= 4'h0;
    end else if (clk_en) begin
      if (wr_irq_st) begin
        irq_status <= (irq_status & ~wbyte[3:0]) | irq_events;
      end else begin
        irq_status <= irq_status | irq_events;
      end
    end
  end

  // Interrupt mask
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      irq_mask <= 4'h0;
    end else if (clk_en) begin
      if (wr_irq_mask) begin
        irq_mask <= wbyte[3:0];
      end
    end
  end

  // Interrupt output lags the status by one cycle
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // Read data selection; unmapped offsets read zero
  always @* begin
    rd_mux = 32'h00000000;
    case (avs_address)
      `OFS_THRESH: begin
        rd_mux[7:0] = brownout_threshold_select;
      end
      `OFS_CAUSE: begin
        rd_mux[`CAUSE_BO_BIT] = brownout_event_flag;
        rd_mux[`CAUSE_BAD_BIT] = bad_threshold_code_flag;
      end
      `OFS_STATUS: begin
        rd_mux[`STAT_TO_BIT] = watchdog_timeout_flag;
        rd_mux[`STAT_PDF_BIT] = powerdown_flag;
      end
      `OFS_IRQ_ST: begin
        rd_mux[3:0] = irq_status;
      end
      `OFS_IRQ_MASK: begin
        rd_mux[3:0] = irq_mask;
      end
      default: begin
        rd_mux = 32'h00000000;
      end
    endcase
  end

  // Bus handshake: one wait cycle, then answer for one cycle
  // Holding waitrequest high by default keeps the master
  // from seeing a stale answer on back-to-back requests
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else if (clk_en) begin
      if ((avs_read || avs_write) && avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        avs_readdata <= avs_read ? rd_mux : 32'h00000000;
      end else begin
        avs_waitrequest <= 1'b1;
      end
    end
  end

  // Power-on full reset comes from the stretcher's reset value
  // and covers PC, interrupts, WDT, ports and SP in the core
  // Both reset outputs are flops on sys_clk only

endmodule // reset_cause_and_brownout_control

// File: hw/reset_stretch.v
// Stretches a reset request into a pulse of a least length
`timescale 1ns/1ps
module reset_stretch #(
  parameter HOLD = 4,
  parameter POR_ON = 1
) (
  input wire sys_clk,
  input wire rst_b,
  input wire clk_en,
  input wire req,
  output reg rst_out
);
  // Cycles still to hold after the request drops
  reg [3:0] left;

  // Level requests keep it high; short ones still get HOLD cycles
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      left <= POR_ON ? HOLD[3:0] : 4'h0;
      rst_out <= POR_ON ? 1'b1 : 1'b0;
    end else if (clk_en) begin
      if (req) begin
        left <= HOLD[3:0];
        rst_out <= 1'b1;
      end else if (left != 4'h0) begin
        left <= left - 4'h1;
        rst_out <= 1'b1;
      end else begin
        rst_out <= 1'b0;
      end
    end
  end
endmodule // reset_stretch

// File: hw/rst_ctl_defines.vh
// Offsets, fields, reset values and timing counts of the reset controller
`ifndef RST_CTL_DEFINES_VH
`define RST_CTL_DEFINES_VH

// System clock rate in MHz
`define CLK_MHZ 250

// Brown-out must persist this long before it resets
`define BO_FILTER_NS 1000
// Least time, so round up to whole cycles
`define BO_FILTER_CYC ((`BO_FILTER_NS * `CLK_MHZ + 999) / 1000)

// Delay from an undefined threshold code to its reset
`define BAD_CODE_DELAY_NS 2000
`define BAD_CODE_CYC ((`BAD_CODE_DELAY_NS * `CLK_MHZ + 999) / 1000)

// Reset hold after the request drops, in cycles; shortest pulse is one more
`define RST_HOLD_CYC 4

// Register byte offsets
`define OFS_THRESH 5'h00
`define OFS_CAUSE 5'h04
`define OFS_STATUS 5'h08
`define OFS_IRQ_ST 5'h0C
`define OFS_IRQ_MASK 5'h10

// Threshold select: power-on value, fixed low-voltage level
`define THRESH_POR 8'h66
// The other four defined codes
`define THRESH_CODE_A 8'h55
`define THRESH_CODE_B 8'h33
`define THRESH_CODE_C 8'h99
`define THRESH_CODE_D 8'hAA

// Reset cause flag bit positions
`define CAUSE_BAD_BIT 1
`define CAUSE_BO_BIT 2

// Core status bit positions
`define STAT_TO_BIT 0
`define STAT_PDF_BIT 1

// Interrupt event bit positions
`define IRQ_BO_BIT 0
`define IRQ_BAD_BIT 1
`define IRQ_WDT_BIT 2
`define IRQ_EXT_BIT 3

// Operating modes
`define MODE_FAST 2'h0
`define MODE_SLOW 2'h1
`define MODE_IDLE 2'h2
`define MODE_SLEEP 2'h3

`endif

// File: tb/core_model.sv
// Behavioural processor core that takes the resets
`timescale 1ns/1ps
module core_model (
  input wire sys_clk,
  input wire sys_reset,
  input wire pc_sp_reset,
  output reg [7:0] pc
);
  // Program counter runs freely; either reset zeroes it
  always @(posedge sys_clk) begin
    if (sys_reset || pc_sp_reset) begin
      pc <= 8'h00;
    end else begin
      pc <= pc + 8'h01;
    end
  end
endmodule // core_model

// File: tb/rst_ctl_properties.sv
// Port assertions for the reset cause and brown-out controller
`timescale 1ns/1ps
module rst_ctl_props (
  input wire sys_clk,
  input wire rst_b,
  input wire clk_en,
  input wire supply_low,
  input wire external_reset_pin_b,
  input wire wdt_timeout,
  input wire [1:0] cpu_mode,
  input wire halt_cmd,
  input wire clr_wdt_cmd,
  input wire sys_reset,
  input wire pc_sp_reset,
  input wire brownout_detect_en,
  input wire [7:0] threshold_select_code,
  input wire watchdog_timeout_flag,
  input wire powerdown_flag
);
  reg [8:0] bo_cnt; // Consecutive armed low-supply cycles
  reg [9:0] bad_cnt; // Cycles an undefined code has been shown
  wire bad_code = threshold_select_code != 8'h66 &&
    threshold_select_code != 8'h55 && threshold_select_code != 8'h33 &&
    threshold_select_code != 8'h99 && threshold_select_code != 8'hAA;
  // Saturating counters, so each threshold is crossed only once
  always @(posedge sys_clk) begin
    if (!rst_b || !(supply_low && brownout_detect_en)) begin
      bo_cnt <= 9'h000;
    end else if (clk_en && bo_cnt != 9'h1FF) begin
      bo_cnt <= bo_cnt + 9'h001;
    end
    if (!rst_b || !bad_code) begin
      bad_cnt <= 10'h000;
    end else if (clk_en && bad_cnt != 10'h3FF) begin
      bad_cnt <= bad_cnt + 10'h001;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  // A frozen block answers nothing, so checks pause with it
  default disable iff (!rst_b || !clk_en);
  // A full reset pulse is never shorter than four cycles
  sequence s_full4;
    sys_reset [*4];
  endsequence
  property p_por;
    $rose(rst_b) |-> sys_reset && !watchdog_timeout_flag &&
      !powerdown_flag && threshold_select_code == 8'h66;
  endproperty
  a_por: assert property (p_por) else $error("Power-on state wrong");
  property p_hold;
    $rose(sys_reset) |-> s_full4;
  endproperty
  a_hold: assert property (p_hold) else $error("Reset too short");
  property p_wdt_run;
    wdt_timeout && !cpu_mode[1] |=> watchdog_timeout_flag &&
      powerdown_flag == $past(powerdown_flag) ##0 s_full4;
  endproperty
  a_wdt_run: assert property (p_wdt_run) else $error("Run time-out");
  property p_wdt_lp;
    wdt_timeout && cpu_mode[1] |=> watchdog_timeout_flag &&
      powerdown_flag ##0 pc_sp_reset [*4];
  endproperty
  a_wdt_lp: assert property (p_wdt_lp) else $error("Sleep time-out");
  property p_bo_off;
    cpu_mode[1] |=> !brownout_detect_en;
  endproperty
  a_bo_off: assert property (p_bo_off) else $error("Detect on");
  property p_bo_fire;
    bo_cnt == 9'd250 |-> ##[0:2] sys_reset;
  endproperty
  a_bo_fire: assert property (p_bo_fire) else $error("No brown-out");
  property p_bad;
    bad_cnt == 10'd498 |-> ##[0:6] threshold_select_code == 8'h66;
  endproperty
  a_bad: assert property (p_bad) else $error("Bad code kept");
  property p_keep;
    !wdt_timeout && !halt_cmd && !clr_wdt_cmd |=>
      $stable(watchdog_timeout_flag) && $stable(powerdown_flag);
  endproperty
  a_keep: assert property (p_keep) else $error("Flags moved");
  property p_ext;
    !external_reset_pin_b |=> sys_reset;
  endproperty
  a_ext: assert property (p_ext) else $error("Pin reset missing");
endmodule // rst_ctl_props
bind reset_cause_and_brownout_control rst_ctl_props u_props (.sys_clk,
  .rst_b, .supply_low, .external_reset_pin_b, .wdt_timeout, .cpu_mode,
  .halt_cmd, .clr_wdt_cmd, .sys_reset, .pc_sp_reset, .brownout_detect_en,
  .threshold_select_code, .watchdog_timeout_flag, .powerdown_flag,
  .clk_en);

// File: tb/tb_reset_cause_and_brownout_control.sv
// Self-checking bench for the reset cause and brown-out controller
`timescale 1ns/1ps
module tb_reset_cause_and_brownout_control;
  reg sys_clk = 1'b0; // 250 MHz system clock
  reg rst_b = 1'b0; // Power-on reset, active low
  reg avs_read = 1'b0, avs_write = 1'b0, supply_low = 1'b0;
  reg external_reset_pin_b = 1'b1, wdt_timeout = 1'b0;
  reg halt_cmd = 1'b0, clr_wdt_cmd = 1'b0;
  reg clk_en = 1'b1; // Dropped once to prove the freeze
  reg [1:0] cpu_mode = 2'h0; // Fast running mode
  reg [4:0] avs_address = 5'h00;
  reg [31:0] avs_writedata = 32'h0;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, sys_reset, pc_sp_reset, brownout_detect_en, irq;
  wire watchdog_timeout_flag, powerdown_flag;
  wire [7:0] threshold_select_code, pc;
  integer n_mismatch = 0, compares = 0, m;
  reg [7:0] q; // Last read data
  reset_cause_and_brownout_control u_dut (.sys_clk, .rst_b, .clk_en,
    .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .supply_low,
    .external_reset_pin_b, .wdt_timeout, .cpu_mode, .halt_cmd,
    .clr_wdt_cmd, .sys_reset, .pc_sp_reset, .brownout_detect_en,
    .threshold_select_code, .watchdog_timeout_flag, .powerdown_flag, .irq);
  core_model u_core (.sys_clk, .sys_reset, .pc_sp_reset, .pc);
  // Clock
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  // Prints the verdict and ends the run
  task conclude;
    begin
      $display("Compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task chk(input [8*8:1] name, input [7:0] exp, input [7:0] got);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("Error %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  // One Avalon transfer, held until waitrequest is sampled low
  task bus(input we, input [4:0] a, input [7:0] d);
    integer i;
    begin
      @(posedge sys_clk);
      avs_read <= !we;
      avs_write <= we;
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      @(posedge sys_clk);
      for (i = 0; i < 50 && avs_waitrequest !== 1'b0; i = i + 1)
        @(posedge sys_clk);
      if (i == 50) begin
        chk("waitreq", 0, 1);
        conclude;
      end
      q = avs_readdata[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask
  task rd(input [4:0] a, input [7:0] exp, input [8*8:1] name);
    begin
      bus(1'b0, a, 8'h00);
      chk(name, exp, q);
    end
  endtask
  // Bounded wait for the full reset to reach a level
  task wait_rst(input v, input integer n);
    integer i;
    begin
      for (i = 0; i < n && sys_reset !== v; i = i + 1)
        @(posedge sys_clk);
      chk("sysrst", v, sys_reset);
      if (sys_reset !== v) conclude;
    end
  endtask
  task t_por;
    begin
      rd(5'h00, 8'h66, "thresh");
      rd(5'h04, 8'h00, "cause");
      rd(5'h14, 8'h00, "unmapped");
      rd(5'h08, 8'h00, "status");
      chk("timeout", 0, watchdog_timeout_flag);
      chk("pdown", 0, powerdown_flag);
      $display("Test por done");
    end
  endtask
  task t_bo;
    begin
      bus(1'b1, 5'h00, 8'h55);
      bus(1'b1, 5'h10, 8'h01);
      rd(5'h10, 8'h01, "mask");
      @(posedge sys_clk);
      supply_low <= 1'b1;
      wait_rst(1'b1, 400);
      supply_low <= 1'b0;
      wait_rst(1'b0, 50);
      rd(5'h00, 8'h55, "thresh");
      chk("irq", 1, irq);
      bus(1'b1, 5'h04, 8'hFF);
      rd(5'h04, 8'h04, "cause");
      bus(1'b1, 5'h04, 8'h00);
      rd(5'h04, 8'h00, "cause");
      bus(1'b1, 5'h0C, 8'h01);
      repeat (2) @(posedge sys_clk);
      chk("irq", 0, irq);
      $display("Test brown-out done");
    end
  endtask
  task t_idle;
    begin
      @(posedge sys_clk);
      cpu_mode <= 2'h2;
      supply_low <= 1'b1;
      repeat (300) @(posedge sys_clk);
      chk("sysrst", 0, sys_reset);
      supply_low <= 1'b0;
      cpu_mode <= 2'h0;
      // A short reset pulse could hide between samples; the flag cannot
      rd(5'h04, 8'h00, "cause");
      $display("Test idle done");
    end
  endtask
  task t_bad;
    begin
      bus(1'b1, 5'h00, 8'h12);
      wait_rst(1'b1, 700);
      wait_rst(1'b0, 50);
      rd(5'h00, 8'h66, "thresh");
      rd(5'h04, 8'h02, "cause");
      bus(1'b1, 5'h04, 8'h00);
      rd(5'h04, 8'h00, "cause");
      $display("Test bad code done");
    end
  endtask
  task t_wdt;
    begin
      @(posedge sys_clk);
      clr_wdt_cmd <= 1'b1;
      @(posedge sys_clk);
      clr_wdt_cmd <= 1'b0;
      halt_cmd <= 1'b1;
      @(posedge sys_clk);
      halt_cmd <= 1'b0;
      @(posedge sys_clk);
      chk("pdown", 1, powerdown_flag);
      for (m = 3; m >= 0; m = m - 1) begin
        cpu_mode <= m[1:0];
        wdt_timeout <= 1'b1;
        @(posedge sys_clk);
        wdt_timeout <= 1'b0;
        @(posedge sys_clk);
        chk("full", m < 2, sys_reset);
        chk("light", m > 1, pc_sp_reset);
        chk("timeout", 1, watchdog_timeout_flag);
        chk("pdown", 1, powerdown_flag);
        repeat (8) @(posedge sys_clk);
        chk("pc", 1, pc < 8'h10);
      end
      rd(5'h08, 8'h03, "status");
      $display("Test watchdog done");
    end
  endtask
  task t_ext;
    begin
      // While frozen the pin must not reach the core reset
      clk_en <= 1'b0;
      external_reset_pin_b <= 1'b0;
      repeat (3) @(posedge sys_clk);
      chk("frozen", 0, sys_reset);
      clk_en <= 1'b1;
      repeat (3) @(posedge sys_clk);
      chk("sysrst", 1, sys_reset);
      external_reset_pin_b <= 1'b1;
      wait_rst(1'b0, 20);
      chk("timeout", 1, watchdog_timeout_flag);
      chk("pdown", 1, powerdown_flag);
      // Bad code, watchdog and pin edge left pending; brown-out cleared
      rd(5'h0C, 8'h0E, "irqstat");
      $display("Test pin reset done");
    end
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    wait_rst(1'b0, 20);
    t_por;
    t_bo;
    t_idle;
    t_bad;
    t_wdt;
    t_ext;
    conclude;
  end
endmodule // tb_reset_cause_and_brownout_control
